// File: core/perf_event_defines.svh
// Offsets, field positions, codes and reset values of the memory event selector block
`ifndef PERF_EVENT_DEFINES_SVH
`define PERF_EVENT_DEFINES_SVH

// Word indices on the register bus (byte address = 4 * index)
`define IDX_SEL0        4'h0
`define IDX_CFG0        4'h6
`define IDX_CNT0        4'ha
`define IDX_MISS        4'he

// Selector word fields
`define EVT_HI          31
`define EVT_LO          25
`define MASK_HI         24
`define MASK_LO         9

// Counter configuration word fields
`define CSEL_HI         15
`define CSEL_LO         13
`define CFG_EN_BIT      12
`define CFG_PAIR_HI     1
`define CFG_PAIR_LO     0

// Selector pairs a counter may listen to
`define PAIR_DAC        2'h0
`define PAIR_SAAT       2'h1
`define PAIR_MOB        2'h2

// Event codes
`define EVT_CANCEL      7'h02
`define EVT_COMPLETE    7'h08
`define EVT_LD_REPLAY   7'h04
`define EVT_ST_REPLAY   7'h05
`define EVT_OB_REPLAY   7'h03

// Configuration selector codes per pair
`define CSEL_DAC        3'h5
`define CSEL_SAAT       3'h2
`define CSEL_MOB        3'h2

// Cause mask bit positions
`define MB_STORE_FULL   2
`define MB_ALIAS        3
`define MB_LD_DONE      0
`define MB_ST_DONE      1
`define MB_SPLIT_LOAD_CAUSE     1
`define MB_SPLIT_STORE_CAUSE     1
`define MB_NO_STA       1
`define MB_NO_STD       3
`define MB_PARTIAL      4
`define MB_UNALIGNED    5

// Reset values
`define RST_WORD        32'h0000_0000
`define RST_ACK         1'b0

`endif

// File: core/perf_event_pkg.sv
// Types shared by the memory event selector block
package perf_event_pkg;

   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;     // Byte address
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avmm_req_s;

   // Raw event levels from the memory pipeline, one cycle per occurrence
   typedef struct packed {
      logic store_buffer_full_cause;   // Cancel, no store request buffer
      logic alias_conflict_cause;      // Cancel, 64K alias conflict
      logic split_load_done;           // Split load completed
      logic split_load_uncached;       // That load was to UC or WC memory
      logic split_store_done;          // Split store completed
      logic split_load_cause;          // Load port replay, split load
      logic split_store_cause;         // Store port replay, split store
      logic ob_no_store_addr;          // Order buffer replay, unknown address
      logic ob_no_store_data;          // Order buffer replay, unknown data
      logic ob_partial_data;           // Order buffer replay, partial overlap
      logic ob_unaligned_addr;         // Order buffer replay, low bits differ
      logic cache_miss;                // Cacheable access missed
      logic uncacheable_access;        // Access to uncacheable memory
   } raw_events_s;

   // Whole state of the block
   typedef struct packed {
      logic [5:0][31:0] sel;     // Selector words, pair*2 + second
      logic [3:0][31:0] cfg;     // Config words of counters 8..11
      logic [3:0][31:0] cnt;     // Counters 8..11
      logic [31:0]      miss;    // Total miss count
      logic             ack;     // Bus answer cycle
      logic [31:0]      rdata;   // Registered read data
   } state_s;

endpackage

// File: core/event_match.sv
// One counter's event match: enable, selector code and cause mask (causes arrive already filtered by code)
`timescale 1ns/100ps
`include "perf_event_defines.svh"

module event_match
(
   input  wire logic [31:0] sel_word,   // Selector word feeding this counter
   input  wire logic [31:0] cfg_word,   // Counter configuration word
   input  wire logic [15:0] cause,      // Live causes for the selected code
   output logic             hit         // Count one this cycle
);

   logic [2:0]  want_csel;   // Selector code the chosen pair needs
   logic [15:0] mask;        // Cause mask from the selector

   // Pair decides which configuration selector code is legal
   always_comb
   begin
      case (cfg_word[`CFG_PAIR_HI:`CFG_PAIR_LO])
         `PAIR_DAC:  want_csel = `CSEL_DAC;
         `PAIR_SAAT: want_csel = `CSEL_SAAT;
         `PAIR_MOB:  want_csel = `CSEL_MOB;
         default:    want_csel = 3'h7;
      endcase
   end

   assign mask = sel_word[`MASK_HI:`MASK_LO];

   // Any enabled cause counts once; several bits may be set together
   assign hit = cfg_word[`CFG_EN_BIT]
              & (cfg_word[`CSEL_HI:`CSEL_LO] == want_csel)
              & (|(mask & cause));

endmodule // event_match

// File: core/memory_perf_event_select.sv
// Memory subsystem performance event selectors and counters 8..11
`timescale 1ns/100ps
`include "perf_event_defines.svh"

module memory_perf_event_select
#(
   parameter int CNT_W = 32   // Counter width, wraps above it
)
(
   input  wire logic                      ref_clk,       // 40 MHz core clock
   input  wire logic                      sys_rst,       // Synchronous, active high
   input  wire perf_event_pkg::avmm_req_s bus_req,       // Avalon-MM request
   output logic [31:0]                    readdata,      // Avalon-MM read data
   output logic                           waitrequest,   // Avalon-MM stall
   input  wire perf_event_pkg::raw_events_s raw_ev       // Raw event levels
);

   // Counters are held in 32-bit words; wider would not fit the bus
   generate
      if (CNT_W < 1 || CNT_W > 32)
      begin : g_bad_width
         $error("CNT_W must lie between 1 and 32");
      end
   endgenerate

   perf_event_pkg::state_s st_q;        // Registered state
   perf_event_pkg::state_s st_d;        // Next state
   logic [3:0]             hit;         // Per counter increment
   logic [3:0]             req_idx;     // Word index of the request
   logic                   take_wr;     // Write takes effect this edge
   logic [31:0]            cnt_mask;    // Keeps counters inside CNT_W bits
   logic                   miss_tick;   // One total miss occurrence

   assign req_idx  = bus_req.address[5:2];
   assign take_wr  = st_q.ack & bus_req.write;
   assign cnt_mask = (CNT_W == 32) ? 32'hffff_ffff
                                   : ((32'h0000_0001 << CNT_W) - 32'h0000_0001);

   // Uncacheable accesses are counted as misses too
   assign miss_tick = raw_ev.cache_miss | raw_ev.uncacheable_access;

   // Selector word for a pair and half: first half 8,9, second 10,11
   function automatic logic [2:0] sel_index(input logic [1:0] pair,
                                            input logic       second);
      logic [2:0] idx;
      idx = {pair, second};
      // Unused pair code falls back to word 0; its causes are zero anyway
      if (pair > `PAIR_MOB)
      begin
         idx = 3'h0;
      end
      return idx;
   endfunction

   // Live cause vector for one pair and the code in its selector
   function automatic logic [15:0] cause_vec(input logic [1:0]                  pair,
                                             input logic [6:0]                  code,
                                             input perf_event_pkg::raw_events_s ev);
      logic [15:0] v;
      v = 16'h0000;
      case (pair)
         // Data cache address control cancellations
         `PAIR_DAC:
         begin
            if (code == `EVT_CANCEL)
            begin
               v[`MB_STORE_FULL] = ev.store_buffer_full_cause;
               v[`MB_ALIAS]      = ev.alias_conflict_cause;
            end
         end
         // Segment and alignment unit: completions and port replays
         `PAIR_SAAT:
         begin
            if (code == `EVT_COMPLETE)
            begin
               // Split loads to UC or WC memory are left out
               v[`MB_LD_DONE] = ev.split_load_done
                              & ~ev.split_load_uncached;
               v[`MB_ST_DONE] = ev.split_store_done;
            end
            else if (code == `EVT_LD_REPLAY)
            begin
               v[`MB_SPLIT_LOAD_CAUSE] = ev.split_load_cause;
            end
            else if (code == `EVT_ST_REPLAY)
            begin
               v[`MB_SPLIT_STORE_CAUSE] = ev.split_store_cause;
            end
         end
         // Memory order buffer load replays
         `PAIR_MOB:
         begin
            if (code == `EVT_OB_REPLAY)
            begin
               v[`MB_NO_STA]    = ev.ob_no_store_addr;
               v[`MB_NO_STD]    = ev.ob_no_store_data;
               v[`MB_PARTIAL]   = ev.ob_partial_data;
               v[`MB_UNALIGNED] = ev.ob_unaligned_addr;
            end
         end
         // Reserved pair code never counts
         default:
         begin
            v = 16'h0000;
         end
      endcase
      return v;
   endfunction

   // Byte lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old_word,
                                         input logic [31:0] new_word,
                                         input logic [3:0]  be);
      logic [31:0] w;
      w = old_word;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            w[8*b +: 8] = new_word[8*b +: 8];
         end
      end
      return w;
   endfunction

   // Read mux; unmapped words read as zero
   function automatic logic [31:0] reg_read(input perf_event_pkg::state_s s,
                                            input logic [3:0]             idx);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (idx < `IDX_CFG0)
      begin
         r = s.sel[idx[2:0]];
      end
      else if (idx < `IDX_CNT0)
      begin
         r = s.cfg[2'(idx - `IDX_CFG0)];
      end
      else if (idx < `IDX_MISS)
      begin
         r = s.cnt[2'(idx - `IDX_CNT0)];
      end
      else if (idx == `IDX_MISS)
      begin
         r = s.miss;
      end
      return r;
   endfunction

   // One matcher per counter, fed by its pair's first or second selector
   generate
      for (genvar k = 0; k < 4; k++)
      begin : g_match
         logic [1:0]  pair;   // Pair this counter listens to
         logic [2:0]  sidx;   // Selector word in use
         logic [15:0] live;   // Causes live for that selector's code

         assign pair = st_q.cfg[k][`CFG_PAIR_HI:`CFG_PAIR_LO];
         // Counters 8,9 take the first selector, 10,11 the second
         assign sidx = sel_index(pair, (k >= 2) ? 1'b1 : 1'b0);
         assign live = cause_vec(pair, st_q.sel[sidx][`EVT_HI:`EVT_LO], raw_ev);

         event_match u_match
         (
            .sel_word (st_q.sel[sidx]),
            .cfg_word (st_q.cfg[k]),
            .cause    (live),
            .hit      (hit[k])
         );
      end
   endgenerate

   // Next state: bus answer, register writes, counting
   always_comb
   begin
      st_d = st_q;

      // Answer comes one cycle after the request is seen
      st_d.ack = (bus_req.read | bus_req.write) & ~st_q.ack;

      // Read data is captured as the answer cycle starts and then held
      if (st_d.ack && bus_req.read)
      begin
         st_d.rdata = reg_read(st_q, req_idx);
      end

      // Selector words
      for (int i = 0; i < 6; i++)
      begin
         if (take_wr && req_idx == 4'(`IDX_SEL0 + i))
         begin
            // Any mix of mask bits is kept as written
            st_d.sel[i] = merge(st_q.sel[i], bus_req.writedata,
                                bus_req.byteenable);
         end
      end

      // Counter configuration words
      for (int i = 0; i < 4; i++)
      begin
         if (take_wr && req_idx == 4'(`IDX_CFG0 + i))
         begin
            st_d.cfg[i] = merge(st_q.cfg[i], bus_req.writedata,
                                bus_req.byteenable);
         end
      end

      // Counters: a preset write and an event in one cycle both count
      for (int i = 0; i < 4; i++)
      begin
         logic [31:0] base;
         base = st_q.cnt[i];
         if (take_wr && req_idx == 4'(`IDX_CNT0 + i))
         begin
            base = merge(st_q.cnt[i], bus_req.writedata, bus_req.byteenable);
         end
         // One per matching cycle, never more
         st_d.cnt[i] = (base + {31'h0000_0000, hit[i]}) & cnt_mask;
      end

      // Total miss count: a clearing write loses no event of that cycle
      if (take_wr && req_idx == `IDX_MISS)
      begin
         st_d.miss = {31'h0000_0000, miss_tick};
      end
      else
      begin
         st_d.miss = st_q.miss + {31'h0000_0000, miss_tick};
      end
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 6; i++)
         begin
            st_q.sel[i] <= `RST_WORD;
         end
         for (int i = 0; i < 4; i++)
         begin
            st_q.cfg[i] <= `RST_WORD;
            st_q.cnt[i] <= `RST_WORD;
         end
         st_q.miss  <= `RST_WORD;
         st_q.ack   <= `RST_ACK;
         st_q.rdata <= `RST_WORD;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Stall until the answer cycle; read data straight from the register
   assign waitrequest = (bus_req.read | bus_req.write) & ~st_q.ack;
   assign readdata    = st_q.rdata;

endmodule // memory_perf_event_select

// File: testbench/perf_event_chk.sv
// Bus timing and miss count checks for the event selector block
`timescale 1ns/100ps
module perf_event_chk
(
   input wire logic                        ref_clk,
   input wire logic                        sys_rst,
   input wire perf_event_pkg::avmm_req_s   bus_req,
   input wire logic [31:0]                 readdata,
   input wire logic                        waitrequest,
   input wire perf_event_pkg::raw_events_s raw_ev
);
   logic        req;       // Any request present
   logic        miss_ev;   // Miss cycle seen
   logic        clr;       // Accepted write to miss word
   logic        rd_ok;     // Read answer cycle
   logic [31:0] miss_q;    // Shadow miss count

   assign req = bus_req.read | bus_req.write;
   assign miss_ev = raw_ev.cache_miss | raw_ev.uncacheable_access;
   assign clr = bus_req.write & ~waitrequest & (bus_req.address[5:2] == 4'he);
   assign rd_ok = bus_req.read & ~waitrequest;

   // Shadow count; an event in the clear cycle still lands
   always_ff @(posedge ref_clk)
      if (sys_rst)
         miss_q <= 32'h0;
      else if (clr)
         miss_q <= {31'h0, miss_ev};
      else
         miss_q <= miss_q + {31'h0, miss_ev};

   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_wait_first: assert property ($rose(req) |-> waitrequest)
      else $error("first request cycle not stalled");
   a_wait_once: assert property (waitrequest |=> !waitrequest)
      else $error("stall longer than one cycle");
   a_wait_idle: assert property (!req |-> !waitrequest)
      else $error("stall without request");
   a_ack_drop: assert property (req && !waitrequest |=> !req || waitrequest)
      else $error("back to back request not stalled");
   a_wait_pair: assert property (req && waitrequest |-> ##1 (req && !waitrequest))
      else $error("held request not answered");
   a_rdata_hold: assert property (!(bus_req.read && waitrequest) |=> $stable(readdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (rd_ok && bus_req.address[5:2] == 4'hf |-> readdata == 32'h0)
      else $error("unmapped word not zero");
   // Read data was taken one edge earlier, so compare with the shadow of that edge
   a_miss_read: assert property (rd_ok && bus_req.address[5:2] == 4'he |-> readdata == $past(miss_q))
      else $error("miss count read wrong");
endmodule // perf_event_chk

// File: testbench/mem_pipe_model.sv
// Memory pipeline stand-in raising raw event levels in short bursts
`timescale 1ns/100ps
module mem_pipe_model
#(
   parameter int BURST = 3   // Cycles per burst
)
(
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        start,
   input  wire perf_event_pkg::raw_events_s pattern,
   output perf_event_pkg::raw_events_s      raw_ev
);
   logic [3:0]                  left_q;   // Cycles still raised
   perf_event_pkg::raw_events_s pat_q;    // Causes of this burst

   // Load a burst; one occurrence per raised cycle
   always_ff @(posedge ref_clk)
      if (sys_rst)
         left_q <= 4'h0;
      else if (start)
      begin
         left_q <= 4'(BURST);
         pat_q  <= pattern;
      end
      else if (left_q != 4'h0)
         left_q <= left_q - 4'h1;

   // Quiet between bursts: no stale causes
   assign raw_ev = (left_q != 4'h0) ? pat_q : '0;
endmodule // mem_pipe_model

// File: testbench/tb.sv
// Self-checking bench for the memory event selector block
`timescale 1ns/100ps
module tb;
   logic                        ref_clk = 1'b0;
   logic                        sys_rst = 1'b1;
   perf_event_pkg::avmm_req_s   bus_req = '0;
   logic [31:0]                 readdata;
   logic                        waitrequest;
   perf_event_pkg::raw_events_s raw_ev;
   logic                        start = 1'b0;
   perf_event_pkg::raw_events_s pattern = '0;
   logic [31:0]                 rd;
   int                          fail_count = 0;
   int                          tests_run = 0;
   logic [15:0] ob_mask [4] = '{16'h0002, 16'h0008, 16'h0010, 16'h0020};
   logic [12:0] ob_ev [4]   = '{13'h0020, 13'h0010, 13'h0008, 13'h0004};

   always #12.5 ref_clk = ~ref_clk;

   memory_perf_event_select dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .readdata(readdata), .waitrequest(waitrequest), .raw_ev(raw_ev));
   mem_pipe_model pipe (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
      .pattern(pattern), .raw_ev(raw_ev));

   task automatic end_of_test;
      $display("Counts: %0d compares, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [5:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      int n;
      n = 0;
      bus_req <= '{read: !wr, write: wr, address: a, byteenable: be, writedata: d};
      @(posedge ref_clk);
      while (waitrequest !== 1'b0)
      begin
         n++;
         if (n > 20)
         begin
            fail_count++;
            end_of_test;
         end
         @(posedge ref_clk);
      end
      rd = readdata;
      bus_req <= '0;
      @(posedge ref_clk);
   endtask

   // Raise one burst of causes, then let it settle
   task automatic fire(input logic [12:0] p);
      start   <= 1'b1;
      pattern <= perf_event_pkg::raw_events_s'(p);
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask

   // Program one counter, preset it to 10h, burst, read back
   task automatic run_case(input logic [1:0] ci, input logic [1:0] pair, input logic [2:0] cs,
      input logic [6:0] code, input logic [15:0] mask, input logic [12:0] p,
      input logic [31:0] exp);
      logic [5:0] ca;
      ca = {2'h0, ci, 2'h0};
      access(1'b1, {1'b0, pair, ci[1], 2'h0}, 4'hf, {code, mask, 9'h000});
      access(1'b1, 6'h18 + ca, 4'hf, {16'h0000, cs, 1'b1, 10'h000, pair});
      access(1'b1, 6'h28 + ca, 4'hf, 32'h0000_0010);
      fire(p);
      access(1'b0, 6'h28 + ca, 4'h0, 32'h0);
      check(rd, exp);
      $display("Case done: counter %0d code %h", ci, code);
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      // Reset values, unmapped word, byte lanes
      for (int i = 0; i < 16; i++)
      begin
         access(1'b0, 6'(4 * i), 4'h0, 32'h0);
         check(rd, 32'h0);
      end
      access(1'b1, 6'h3c, 4'hf, 32'hffff_ffff);
      access(1'b0, 6'h3c, 4'h0, 32'h0);
      check(rd, 32'h0);
      access(1'b1, 6'h0c, 4'h1, 32'hffff_ffff);
      access(1'b0, 6'h0c, 4'h0, 32'h0);
      check(rd, 32'h0000_00ff);
      $display("Test done: registers");
      // Per-event table, expected from codes and masks
      run_case(2'h0, 2'h0, 3'h5, 7'h02, 16'h0004, 13'h1000, 32'h13);
      run_case(2'h2, 2'h0, 3'h5, 7'h02, 16'h0008, 13'h0800, 32'h13);
      run_case(2'h1, 2'h0, 3'h2, 7'h02, 16'h0004, 13'h1000, 32'h10);
      run_case(2'h0, 2'h1, 3'h2, 7'h08, 16'h0001, 13'h0400, 32'h13);
      run_case(2'h1, 2'h1, 3'h2, 7'h08, 16'h0001, 13'h0600, 32'h10);
      run_case(2'h2, 2'h1, 3'h2, 7'h08, 16'h0002, 13'h0100, 32'h13);
      run_case(2'h3, 2'h1, 3'h2, 7'h08, 16'h0003, 13'h0500, 32'h13);
      run_case(2'h2, 2'h1, 3'h2, 7'h04, 16'h0002, 13'h0080, 32'h13);
      run_case(2'h3, 2'h1, 3'h2, 7'h05, 16'h0002, 13'h0040, 32'h13);
      run_case(2'h3, 2'h1, 3'h2, 7'h04, 16'h0002, 13'h0040, 32'h10);
      for (int i = 0; i < 4; i++)
         run_case(i[1:0], 2'h2, 3'h2, 7'h03, ob_mask[i], ob_ev[i], 32'h13);
      run_case(2'h0, 2'h2, 3'h2, 7'h03, 16'h0002, 13'h0008, 32'h10);
      // Miss count: clear, both causes, then uncacheable alone
      access(1'b1, 6'h38, 4'hf, 32'h0);
      fire(13'h0003);
      access(1'b0, 6'h38, 4'h0, 32'h0);
      check(rd, 32'h3);
      fire(13'h0001);
      access(1'b0, 6'h38, 4'h0, 32'h0);
      check(rd, 32'h6);
      $display("Test done: miss count");
      end_of_test;
   end
endmodule // tb

bind memory_perf_event_select perf_event_chk chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest), .raw_ev(raw_ev));
